/* include/rmcg_defs.svh */
// Register offsets, field positions, masks and reset values of the run-mode clock gate.
`ifndef RMCG_DEFS_SVH
`define RMCG_DEFS_SVH
`define RMCG_RUN_GATE_OFF      12'h100
`define RMCG_IRQ_STATUS_OFF    12'h104
`define RMCG_IRQ_MASK_OFF      12'h108
`define RMCG_SLEEP_GATE_OFF    12'h110
`define RMCG_DEEP_GATE_OFF     12'h120
`define RMCG_RUN_CFG_OFF       12'h060
`define RMCG_RUN_GATE_RST      32'h0000_0040
`define RMCG_RUN_GATE_WMASK    32'h0011_0308
`define RMCG_RUN_GATE_FIXED    32'h0000_0040
`define RMCG_CFG_WMASK         32'h0000_0001
`define RMCG_PWM_BIT           20
`define RMCG_ADC_BIT           16
`define RMCG_RATE_LSB          8
`define RMCG_RATE_MSB          9
`define RMCG_WDOG_BIT          3
`define RMCG_AUTO_GATE_BIT     0
`define RMCG_NUM_UNITS         3
`define RMCG_EVT_PWM_FAULT     0
`define RMCG_EVT_ADC_FAULT     1
`define RMCG_EVT_WDOG_FAULT    2
`define RMCG_EVT_WIDTH         3
`define RMCG_ZERO32            32'h0000_0000
`endif

/* include/rmcg_pkg.sv */
// Types shared by the run-mode clock gate files.
package rmcg_pkg;
   // Power state of the core, one-hot coded.
   typedef enum logic [2:0] {
      RMCG_RUN   = 3'h1,
      RMCG_SLEEP = 3'h2,
      RMCG_DEEP  = 3'h4
   } rmcg_pwr_e;
   // Converter sample-rate selections.
   typedef enum logic [1:0] {
      RMCG_RATE_125K = 2'h0,
      RMCG_RATE_250K = 2'h1
   } rmcg_rate_e;
endpackage

/* rtl/rmcg_gate_sel.sv */
// Choice of the one active gating word for all units from the power state.
`timescale 1ns/1ps
`include "rmcg_defs.svh"
module rmcg_gate_sel (
   input  wire logic [31:0] i_run_gate,
   input  wire logic [31:0] i_sleep_gate,
   input  wire logic [31:0] i_deep_gate,
   input  wire logic        i_auto_gate,
   input  wire logic [2:0]  i_pwr_state,
   output wire logic [31:0] o_active_gate
);
   // Low-power words apply only when auto gating is selected.
   wire logic use_sleep;
   wire logic use_deep;
   assign use_sleep = i_auto_gate && (i_pwr_state == rmcg_pkg::RMCG_SLEEP);
   assign use_deep  = i_auto_gate && (i_pwr_state == rmcg_pkg::RMCG_DEEP);
   assign o_active_gate = use_deep  ? i_deep_gate :
                          use_sleep ? i_sleep_gate : i_run_gate;
endmodule

/* rtl/rmcg_fault_chk.sv */
// Detection of bus accesses to units whose clock is stopped.
`timescale 1ns/1ps
`include "rmcg_defs.svh"
module rmcg_fault_chk (
   input  wire logic [2:0] i_unit_sel,
   input  wire logic [2:0] i_unit_en,
   input  wire logic       i_unit_access,
   output wire logic [2:0] o_fault
);
   // One fault term per unit, built by a loop so units share one shape.
   genvar g;
   generate
      for (g = 0; g < `RMCG_NUM_UNITS; g = g + 1) begin : g_unit
         assign o_fault[g] = i_unit_access && i_unit_sel[g] && !i_unit_en[g];
      end
   endgenerate
endmodule

/* rtl/rmcg_top.sv */
// Run-mode clock gating register block with APB slave, fault detection and interrupt.
//
// Summary of operation
// - Each gate bit enables one unit clock.
// - Access to a gated unit gives fault.
// - Register resets to 0x00000040.
// - Bit 20 gates the PWM unit.
// - Bit 16 gates converter unit zero.
// - Bit 3 gates the watchdog unit.
// - Bits 9:8 select converter sample rate.
// - Bit 6 reads one, other reserved zero.
// - Run register governs normal running clocks.
// - Low-power registers need auto select.
`timescale 1ns/1ps
`include "rmcg_defs.svh"
module rmcg_top (
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic [2:0]  i_pwr_state,
   input  wire logic [2:0]  i_unit_sel,
   input  wire logic        i_unit_access,
   output logic             o_unit_fault,
   output logic             o_pwm_clk_en,
   output logic             o_adc_clk_en,
   output logic             o_wdog_clk_en,
   output logic      [1:0]  o_sample_rate,
   output logic             o_irq
);
   // Each gating word stores its writable bits and the fixed bit; fixed bits are merged again on read.
   logic [31:0] run_gate;
   logic [31:0] sleep_gate;
   logic [31:0] deep_gate;
   // Run clock configuration, holding only the auto gating select.
   logic [31:0] run_cfg;
   // Sticky fault status and its mask, same layout.
   logic [2:0]  irq_status;
   logic [2:0]  irq_mask;
   // APB decode wires.
   wire logic        setup;
   wire logic        wr_en;
   wire logic        hit_run;
   wire logic        hit_sleep;
   wire logic        hit_deep;
   wire logic        hit_cfg;
   wire logic        hit_stat;
   wire logic        hit_mask;
   wire logic        mapped;
   wire logic [31:0] rd_mux;
   wire logic [31:0] run_view;
   wire logic [31:0] sleep_view;
   wire logic [31:0] deep_view;
   wire logic [31:0] active_gate;
   wire logic [2:0]  unit_en;
   wire logic [2:0]  fault_vec;
   wire logic [31:0] next_run_gate;
   wire logic [2:0]  next_irq_status;
   wire logic [2:0]  next_irq_mask;

   // Answer on the access phase only; o_pready is registered, so a transfer takes
   // one setup and two access cycles. The cost is one cycle, the gain a clean output.
   assign setup   = i_psel && i_penable && !o_pready;
   assign wr_en   = setup && i_pwrite;
   assign hit_run   = (i_paddr == `RMCG_RUN_GATE_OFF);
   assign hit_sleep = (i_paddr == `RMCG_SLEEP_GATE_OFF);
   assign hit_deep  = (i_paddr == `RMCG_DEEP_GATE_OFF);
   assign hit_cfg   = (i_paddr == `RMCG_RUN_CFG_OFF);
   assign hit_stat  = (i_paddr == `RMCG_IRQ_STATUS_OFF);
   assign hit_mask  = (i_paddr == `RMCG_IRQ_MASK_OFF);
   assign mapped    = hit_run || hit_sleep || hit_deep || hit_cfg || hit_stat || hit_mask;

   assign run_view   = (run_gate & `RMCG_RUN_GATE_WMASK) | `RMCG_RUN_GATE_FIXED;
   assign sleep_view = (sleep_gate & `RMCG_RUN_GATE_WMASK) | `RMCG_RUN_GATE_FIXED;
   assign deep_view  = (deep_gate & `RMCG_RUN_GATE_WMASK) | `RMCG_RUN_GATE_FIXED;

   // Read selection; unmapped addresses read zero and answer with an error.
   assign rd_mux = hit_run   ? run_view :
                   hit_sleep ? sleep_view :
                   hit_deep  ? deep_view :
                   hit_cfg   ? (run_cfg & `RMCG_CFG_WMASK) :
                   hit_stat  ? {29'h0000_0000, irq_status} :
                   hit_mask  ? {29'h0000_0000, irq_mask} : `RMCG_ZERO32;

   assign next_run_gate = i_pwdata & `RMCG_RUN_GATE_WMASK;

   // Pick the word that governs the unit clocks in the present power state.
   rmcg_gate_sel u_gate_sel (
      .i_run_gate    (run_gate),
      .i_sleep_gate  (sleep_gate),
      .i_deep_gate   (deep_gate),
      .i_auto_gate   (run_cfg[`RMCG_AUTO_GATE_BIT]),
      .i_pwr_state   (i_pwr_state),
      .o_active_gate (active_gate)
   );

   assign unit_en[`RMCG_EVT_PWM_FAULT]  = active_gate[`RMCG_PWM_BIT];
   assign unit_en[`RMCG_EVT_ADC_FAULT]  = active_gate[`RMCG_ADC_BIT];
   assign unit_en[`RMCG_EVT_WDOG_FAULT] = active_gate[`RMCG_WDOG_BIT];

   // Fault terms for accesses that target a stopped unit.
   rmcg_fault_chk u_fault_chk (
      .i_unit_sel    (i_unit_sel),
      .i_unit_en     (unit_en),
      .i_unit_access (i_unit_access),
      .o_fault       (fault_vec)
   );

   // Set wins over a write-one clear in the same cycle, so no fault is lost.
   assign next_irq_status = (irq_status & ~((wr_en && hit_stat) ? i_pwdata[2:0] : 3'h0))
                            | fault_vec;

   // The interrupt uses the mask as written this cycle, so masking takes hold at once.
   assign next_irq_mask = (wr_en && hit_mask) ? i_pwdata[2:0] : irq_mask;

   // APB answer registers.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= `RMCG_ZERO32;
      end else begin
         o_pready  <= setup;
         o_pslverr <= setup && !mapped;
         o_prdata  <= (setup && !i_pwrite) ? rd_mux : `RMCG_ZERO32;
      end
   end

   // Gating words; all writable bits start cleared so units begin unclocked.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         run_gate   <= `RMCG_RUN_GATE_RST;
         sleep_gate <= `RMCG_RUN_GATE_RST;
         deep_gate  <= `RMCG_RUN_GATE_RST;
      end else if (wr_en) begin
         if (hit_run) begin
            run_gate <= next_run_gate | `RMCG_RUN_GATE_FIXED;
         end
         if (hit_sleep) begin
            sleep_gate <= next_run_gate | `RMCG_RUN_GATE_FIXED;
         end
         if (hit_deep) begin
            deep_gate <= next_run_gate | `RMCG_RUN_GATE_FIXED;
         end
      end
   end

   // Configuration and interrupt mask registers.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         run_cfg  <= `RMCG_ZERO32;
         irq_mask <= 3'h0;
      end else if (wr_en) begin
         if (hit_cfg) begin
            run_cfg <= i_pwdata & `RMCG_CFG_WMASK;
         end
         if (hit_mask) begin
            irq_mask <= i_pwdata[2:0];
         end
      end
   end

   // Sticky status, a registered fault strobe and the level interrupt.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_status   <= 3'h0;
         o_unit_fault <= 1'b0;
         o_irq        <= 1'b0;
      end else begin
         irq_status   <= next_irq_status;
         o_unit_fault <= |fault_vec;
         o_irq        <= |(next_irq_status & next_irq_mask);
      end
   end

   // Unit clock enables and sample rate, registered so each output is a flop.
   // The enable feeds a glitch-free gate cell in the unit, never a logic AND.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pwm_clk_en  <= 1'b0;
         o_adc_clk_en  <= 1'b0;
         o_wdog_clk_en <= 1'b0;
         o_sample_rate <= rmcg_pkg::RMCG_RATE_125K;
      end else begin
         o_pwm_clk_en  <= unit_en[`RMCG_EVT_PWM_FAULT];
         o_adc_clk_en  <= unit_en[`RMCG_EVT_ADC_FAULT];
         o_wdog_clk_en <= unit_en[`RMCG_EVT_WDOG_FAULT];
         o_sample_rate <= run_gate[`RMCG_RATE_MSB:`RMCG_RATE_LSB];
      end
   end

   // Write of the run word reaches the PWM enable two edges later in run state.
   pwm_follow_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (wr_en && hit_run && i_pwr_state == rmcg_pkg::RMCG_RUN)
      ##1 (i_pwr_state == rmcg_pkg::RMCG_RUN)
      |=> (o_pwm_clk_en == $past(i_pwdata[`RMCG_PWM_BIT], 2)))
      else $error("PWM enable did not follow run word write");

   // The converter enable follows a run word write in the same way.
   adc_follow_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (wr_en && hit_run && i_pwr_state == rmcg_pkg::RMCG_RUN)
      ##1 (i_pwr_state == rmcg_pkg::RMCG_RUN)
      |=> (o_adc_clk_en == $past(i_pwdata[`RMCG_ADC_BIT], 2)))
      else $error("Converter enable did not follow run word write");

   // The watchdog enable follows a run word write in the same way.
   wdog_follow_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (wr_en && hit_run && i_pwr_state == rmcg_pkg::RMCG_RUN)
      ##1 (i_pwr_state == rmcg_pkg::RMCG_RUN)
      |=> (o_wdog_clk_en == $past(i_pwdata[`RMCG_WDOG_BIT], 2)))
      else $error("Watchdog enable did not follow run word write");

   // The rate output takes the run word field whatever the power state.
   rate_follow_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (wr_en && hit_run) |-> ##2 (o_sample_rate == $past(i_pwdata[9:8], 2)))
      else $error("Sample rate did not follow run word write");

   // An access to a stopped unit answers with a fault strobe one edge later.
   fault_gated_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (i_unit_access && (i_unit_sel & ~unit_en) != 3'h0) |=> o_unit_fault)
      else $error("Access to stopped unit gave no fault");

   fault_clean_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (!i_unit_access || (i_unit_sel & ~unit_en) == 3'h0) |=> !o_unit_fault)
      else $error("Fault raised for a clocked unit");

   // Reserved places of the run word read their fixed values.
   reserved_read_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (setup && !i_pwrite && hit_run)
      |=> (o_prdata[6] && o_prdata[31:21] == 11'h000 && o_prdata[19:17] == 3'h0
           && o_prdata[15:10] == 6'h00 && o_prdata[7] == 1'b0 && o_prdata[5:4] == 2'h0
           && o_prdata[2:0] == 3'h0))
      else $error("Reserved run word bits read wrong");

   reserved_write_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (wr_en && hit_run) |=> ((run_gate & ~`RMCG_RUN_GATE_WMASK) == `RMCG_RUN_GATE_FIXED))
      else $error("Write changed a reserved bit");

   // Without auto select the run word alone drives the unit clocks.
   auto_gate_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (!run_cfg[`RMCG_AUTO_GATE_BIT]) |-> (active_gate == run_gate))
      else $error("Low-power word used without auto select");

   run_state_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (i_pwr_state == rmcg_pkg::RMCG_RUN) |-> (active_gate == run_gate))
      else $error("Run state not governed by run word");

   // The first edge after reset sees the reset word and a stopped PWM unit.
   reset_val_a: assert property (@(posedge i_core_clk)
      $fell(i_rst) |-> (run_view == `RMCG_RUN_GATE_RST && !o_pwm_clk_en))
      else $error("Run word reset value wrong");

   // The interrupt level always matches the stored status under the stored mask.
   irq_level_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
      o_irq == |(irq_status & irq_mask))
      else $error("Interrupt level mismatches masked status");

   // Ready is a one-cycle pulse; an access phase held past it is answered again every second cycle.
   ready_pulse_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
      o_pready |=> !o_pready)
      else $error("Ready stood for more than one cycle");

   // An unmapped place answers with an error and reads zero.
   error_answer_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (setup && !mapped) |=> (o_pready && o_pslverr && o_prdata == `RMCG_ZERO32))
      else $error("Unmapped access not refused");

   // A refused write leaves the run word, configuration and mask registers alone.
   unmapped_keep_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (wr_en && !mapped) |=> ($stable(run_gate) && $stable(run_cfg) && $stable(irq_mask)))
      else $error("Refused write changed a register");

   // A fault sets its status bit even when a clear lands in the same cycle.
   status_set_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (fault_vec != 3'h0) |=> ((irq_status & $past(fault_vec)) == $past(fault_vec)))
      else $error("Fault did not set its status bit");

   // A write of ones clears the addressed status bits when no new fault arrives.
   status_clear_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (wr_en && hit_stat && fault_vec == 3'h0)
      |=> ((irq_status & $past(i_pwdata[2:0])) == 3'h0))
      else $error("Status bits not cleared by write of ones");

   // Reset also stops the other units and returns the sample rate to its lowest code.
   reset_outs_a: assert property (@(posedge i_core_clk)
      $fell(i_rst) |-> (!o_adc_clk_en && !o_wdog_clk_en && o_sample_rate == 2'h0))
      else $error("Unit outputs not cleared by reset");
endmodule

/* sim/rmcg_unit_model.sv */
// Model of the peripheral side that makes accesses to gated units.
`timescale 1ns/1ps
module rmcg_unit_model (
   input  wire logic       i_core_clk,
   input  wire logic       i_go,
   input  wire logic [2:0] i_sel,
   output logic            o_unit_access,
   output logic      [2:0] o_unit_sel
);
   // One access cycle per request. Between accesses the select shows the
   // inverse of its last value, so a decoder that ignores the strobe is seen.
   initial begin
      o_unit_access = 1'b0;
      o_unit_sel    = 3'h0;
   end
   // access after enable: the bench enables a unit first where it expects no fault.
   always @(posedge i_core_clk) begin
      o_unit_access <= i_go;
      o_unit_sel    <= i_go ? i_sel : ~o_unit_sel;
   end
endmodule

/* sim/run_mode_clock_gating_tb.sv */
// Self-checking bench for the run-mode clock gate block.
`timescale 1ns/1ps
`include "rmcg_defs.svh"
module run_mode_clock_gating_tb;
   logic        clk, rst, psel, penable, pwrite, go, access, fault, irq;
   logic        pwm_en, adc_en, wdog_en, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, d;
   logic [2:0]  pwr, sel, usel;
   logic [1:0]  rate;
   logic        err;
   int          error_cnt, checked, cyc, seed, u;
   int          gbit[3] = '{20, 16, 3};
   rmcg_top DUT (.i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_pwr_state(pwr), .i_unit_sel(usel),
      .i_unit_access(access), .o_unit_fault(fault), .o_pwm_clk_en(pwm_en),
      .o_adc_clk_en(adc_en), .o_wdog_clk_en(wdog_en), .o_sample_rate(rate), .o_irq(irq));
   rmcg_unit_model PEER (.i_core_clk(clk), .i_go(go), .i_sel(sel),
      .o_unit_access(access), .o_unit_sel(usel));
   // Clock of 50 ns period.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // A hang counts as a mismatch and ends the run.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   // Prints the counts and the verdict, then stops.
   task automatic tally_and_finish();
      $display("errors %0d of %0d compares", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Compares one value and counts the outcome.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; the request holds until pready is seen at an edge.
   // Only the bench timeout ends a wait that never sees an answer.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      q = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      pwdata  <= ~wd;
   endtask
   // What the run word must read after a write: only writable bits land.
   function automatic logic [31:0] exp_run(input logic [31:0] w);
      return (w & `RMCG_RUN_GATE_WMASK) | `RMCG_RUN_GATE_FIXED;
   endfunction
   // Expected enables and rate packed as pwm, adc, wdog, rate.
   function automatic logic [31:0] exp_out(input logic [31:0] g, input logic [31:0] r);
      return {27'h0, g[20], g[16], g[3], r[9:8]};
   endfunction
   // Writes the run word and checks read-back and the unit outputs.
   task automatic run_word(input logic [31:0] w);
      apb(1'b1, `RMCG_RUN_GATE_OFF, w);
      repeat (2) @(posedge clk);
      #1;
      chk({27'h0, pwm_en, adc_en, wdog_en, rate}, exp_out(exp_run(w), w));
      apb(1'b0, `RMCG_RUN_GATE_OFF, 32'h0);
      chk(q, exp_run(w));
      chk({31'h0, err}, 32'h0);
   endtask
   // Makes one peripheral access and checks the fault and interrupt lines.
   task automatic poke(input int un, input logic ef, input logic ei);
      go <= 1'b1;
      sel <= 3'h1 << un;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      #1;
      chk({30'h0, fault, irq}, {30'h0, ef, ei});
   endtask
   initial begin
      seed = 91;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      go = 1'b0;
      sel = 3'h0;
      pwr = 3'h1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, `RMCG_RUN_GATE_OFF, 32'h0);
      chk(q, 32'h0000_0040);
      // gate bits: each writable field set alone, then random words.
      foreach (gbit[i]) run_word(32'h1 << gbit[i]);
      // rate kept legal: both documented codes, upper rate bit clear.
      run_word(32'h0000_0100);
      run_word(32'hFFFF_FDFF);
      repeat (8) begin
         d = $random(seed);
         run_word(d & 32'hFFFF_FDFF);
      end
      // Unmapped place refuses and leaves the run word alone.
      apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, `RMCG_RUN_GATE_OFF, 32'h0);
      chk(q, exp_run(d & 32'hFFFF_FDFF));
      run_word(32'h0000_0000);
      // Faults per unit: masked in for units 0 and 2, masked out for unit 1, cleared, then enabled.
      for (u = 0; u < 3; u++) begin
         apb(1'b1, `RMCG_IRQ_MASK_OFF, (u == 1) ? 32'h0 : 32'h1 << u);
         poke(u, 1'b1, u != 1);
         apb(1'b0, `RMCG_IRQ_STATUS_OFF, 32'h0);
         chk(q, 32'h1 << u);
         apb(1'b1, `RMCG_IRQ_STATUS_OFF, 32'h1 << u);
         @(posedge clk);
         #1;
         chk({31'h0, irq}, 32'h0);
         // read-modify-write keeps the reserved bits read.
         apb(1'b0, `RMCG_RUN_GATE_OFF, 32'h0);
         apb(1'b1, `RMCG_RUN_GATE_OFF, q | (32'h1 << gbit[u]));
         poke(u, 1'b0, 1'b0);
         apb(1'b1, `RMCG_RUN_GATE_OFF, 32'h0000_0040);
      end
      // Low-power words count only with auto select in sleep or deep sleep.
      apb(1'b1, `RMCG_SLEEP_GATE_OFF, 32'h0010_0000);
      apb(1'b1, `RMCG_DEEP_GATE_OFF, 32'h0000_0008);
      for (u = 0; u < 4; u++) begin
         apb(1'b1, `RMCG_RUN_CFG_OFF, {31'h0, u != 0});
         pwr <= (u == 3) ? 3'h4 : (u == 2) ? 3'h1 : 3'h2;
         repeat (3) @(posedge clk);
         #1;
         d = (u == 1) ? 32'h4 : (u == 3) ? 32'h1 : 32'h0;
         chk({29'h0, pwm_en, adc_en, wdog_en}, d);
      end
      // A second reset in mid-run brings back the reset word and stops every unit.
      apb(1'b1, `RMCG_RUN_GATE_OFF, 32'h0011_0308);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, `RMCG_RUN_GATE_OFF, 32'h0);
      chk(q, 32'h0000_0040);
      chk({27'h0, pwm_en, adc_en, wdog_en, rate}, 32'h0);
      tally_and_finish();
   end
endmodule
